// ### hw/usf_core.sv
// Purpose: Serial transceiver with APB registers, framing and status flags
// Assumes: APB3 slave, one wait state; serial pins asynchronous to SYS_CLK
// Notes:   Baud divisor gives the 16x tick; zero stops the internal clock
//
// Notes on behaviour
// R1 - parity_enable turns parity on, only for seven and eight bit frames
// R2 - parity select 00 odd, 01 even, 10 mark, 11 space
// R3 - lo=1 hi=0: start, seven data, optional parity, stop bits
// R4 - both zero: start, eight data, optional parity, stop bits
// R5 - hi=1 lo=0: nine data, no parity; ninth from tx_ninth_bit to rx_ninth_bit
// R6 - both one: loopback, transmitter feeds receiver, nine bit frame
// R7 - two_stop_bits selects one or two transmitted stop bits
// R8 - short_last_stop makes the final stop bit seven eighths long
// R9 - any_error_flag high when overrun, framing or parity flag is set
// R10 - received character moves to holding buffer, sets full; buffer read clears it
// R11 - tx_buffer_empty set on reset and on transfer, cleared by buffer write
// R12 - error flags latch, cleared by status register read and reset
// R13 - attention_mode set by software, cleared on receiving ninth bit one
// R14 - tx_active high while sending, low after last stop bit
// R15 - rx_break_flag set by framing error, cleared when receive line high
// R16 - asynchronous mode uses clock at sixteen times the bit rate
// R17 - synchronous mode: drive on rising edge, sample on falling edge
// R18 - receiver and transmitter each pick internal or external clock
// R19 - transmit pin carries serial data only when tx_pin_enable set
// R20 - receiver checks start bit at half bit, then samples mid-bit
// R21 - finished shifter reloads from holding buffer for double buffering
// R22 - rx and tx interrupt enables gate requests, cleared on reset
// R23 - tx interrupt pending while buffer empty and enabled
// R24 - rx interrupt pending while buffer full and enabled
// R25 - receiver needs only one stop bit
// R26 - framing on low stop, parity on mismatch, overrun when buffer still full
`timescale 1ns/10ps
`include "usf_params.svh"
module usf_core import usf_pkg::*; (
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        SERIAL_RX_PIN,
  output logic             SERIAL_TX_PIN,
  output logic             SERIAL_TX_OE_N,
  input  wire logic        EXT_CLOCK_IN,
  output logic             EXT_CLOCK_OUT,
  output logic             EXT_CLOCK_OE_N,
  output logic             TX_IRQ,
  output logic             RX_IRQ
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  ////////////////////////////////////////////////////////////////////////////
  // Registers and flags
  logic [4:0]  ctrl_r;
  logic [7:0]  cfg_r;
  logic [15:0] baud_r;
  logic [7:0]  txbuf_r;
  logic [7:0]  rxbuf_r;
  logic        rx_ninth_bit_r;
  logic        tx_buffer_empty_r;
  logic        rx_buffer_full_r;
  logic        ovr_r;
  logic        fe_r;
  logic        pe_r;
  logic        spare_r;
  logic        attention_mode_r;
  logic        txact_r;
  logic        brk_r;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode; one wait state so every answer comes from a flop
  logic        acc;
  logic        wr;
  logic        rd;
  logic        hit;
  logic [7:0]  rd_val;
  logic [15:0] rd_wide;
  logic        rd_stat_r;

  assign acc = PSEL & PENABLE & PREADY;
  assign wr  = acc & PWRITE;
  assign rd  = acc & ~PWRITE;

  function automatic logic at(input logic [11:0] a, input logic [9:0] idx);
    at = (a[11:2] == idx) && (a[1:0] == 2'h0);
  endfunction

  always_comb begin
    hit     = 1'b1;
    rd_val  = 8'h00;
    rd_wide = 16'h0000;
    // R9 global error bit
    if (at(PADDR, `USF_IDX_CTRL)) begin
      rd_val = {ctrl_r, ovr_r | fe_r | pe_r, rx_buffer_full_r, tx_buffer_empty_r};
    end else if (at(PADDR, `USF_IDX_RXSTAT)) begin
      rd_val = {ovr_r, fe_r, pe_r, spare_r, rx_ninth_bit_r, attention_mode_r, txact_r, brk_r};
    end else if (at(PADDR, `USF_IDX_CFG)) begin
      rd_val = cfg_r;
    end else if (at(PADDR, `USF_IDX_TXBUF)) begin
      rd_val = txbuf_r;
    end else if (at(PADDR, `USF_IDX_RXBUF)) begin
      rd_val = rxbuf_r;
    end else if (at(PADDR, `USF_IDX_BAUD)) begin
      rd_wide = baud_r;
    end else begin
      hit = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      PREADY    <= 1'b0;
      PRDATA    <= 32'h00000000;
      PSLVERR   <= 1'b0;
      rd_stat_r <= 1'b0;
    end else begin
      PREADY  <= PSEL & PENABLE & ~PREADY;
      PSLVERR <= PSEL & PENABLE & ~PREADY & ~hit;
      if (PSEL && PENABLE && !PREADY) begin
        PRDATA    <= {16'h0000, rd_wide | {8'h00, rd_val}};
        rd_stat_r <= at(PADDR, `USF_IDX_RXSTAT);
      end
    end
  end

  logic wr_ctrl;
  logic wr_stat;
  logic wr_txb;
  logic rd_rxb;
  logic rd_stat;
  assign wr_ctrl = wr & at(PADDR, `USF_IDX_CTRL);
  assign wr_stat = wr & at(PADDR, `USF_IDX_RXSTAT);
  assign wr_txb  = wr & at(PADDR, `USF_IDX_TXBUF);
  assign rd_rxb  = rd & at(PADDR, `USF_IDX_RXBUF);
  assign rd_stat = rd & rd_stat_r;

  // R22 enables reset to zero
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ctrl_r  <= `USF_CTRL_RST;
      cfg_r   <= `USF_CFG_RST;
      baud_r  <= `USF_BAUD_RST;
      txbuf_r <= 8'h00;
      spare_r <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= PWDATA[7:3];
      end
      if (wr && at(PADDR, `USF_IDX_CFG)) begin
        cfg_r <= PWDATA[7:0];
      end
      if (wr && at(PADDR, `USF_IDX_BAUD)) begin
        baud_r <= PWDATA[15:0];
      end
      if (wr_txb) begin
        txbuf_r <= PWDATA[7:0];
      end
      if (wr_stat) begin
        spare_r <= PWDATA[`USF_R_SPARE];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame format
  logic       parity_enable;
  logic [1:0] psel;
  logic       nine;
  logic       n7;
  logic       loop;
  logic       par_on;
  logic [3:0] nd;
  logic       two_stop_bits;
  logic       short_last_stop;
  logic       ssel;
  logic       xr;
  logic       xt;

  assign parity_enable   = ctrl_r[`USF_C_PEN - 3];
  assign psel  = ctrl_r[`USF_C_PSELHI - 3 -: 2];
  assign nine  = ctrl_r[`USF_C_LENHI - 3];
  assign n7    = ctrl_r[`USF_C_LENLO - 3] & ~nine;
  assign loop  = ctrl_r[`USF_C_LENHI - 3] & ctrl_r[`USF_C_LENLO - 3];
  assign two_stop_bits  = cfg_r[`USF_G_TWO_STOP_BITS];
  assign short_last_stop = cfg_r[`USF_G_SHORT_LAST_STOP];
  assign ssel  = cfg_r[`USF_G_SSEL];
  assign xr    = cfg_r[`USF_G_RX_EXT_CLOCK_SEL];
  assign xt    = cfg_r[`USF_G_TX_EXT_CLOCK_SEL];
  // R1 parity only without ninth bit
  assign par_on = parity_enable & ~nine;
  // R3 R4 R5 R6 data bit count
  assign nd = nine ? 4'h9 : (n7 ? 4'h7 : 4'h8);

  ////////////////////////////////////////////////////////////////////////////
  // Clock sources; pins pass two flops, third flop only finds edges
  logic [15:0] div_r;
  logic        int_tick;
  logic        int_clk_r;
  logic        ck_s1;
  logic        ck_s2;
  logic        ck_s3;
  logic        rx_s1;
  logic        rx_s2;

  assign int_tick = (baud_r != 16'h0000) && (div_r == baud_r - 16'h0001);

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      div_r     <= 16'h0000;
      int_clk_r <= 1'b0;
    end else begin
      div_r <= int_tick || baud_r == 16'h0000 ? 16'h0000 : div_r + 16'h0001;
      if (int_tick) begin
        int_clk_r <= ~int_clk_r;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      {ck_s1, ck_s2, ck_s3} <= 3'h0;
      {rx_s1, rx_s2}        <= 2'h3;
    end else begin
      {ck_s1, ck_s2, ck_s3} <= {EXT_CLOCK_IN, ck_s1, ck_s2};
      {rx_s1, rx_s2}        <= {SERIAL_RX_PIN, rx_s1};
    end
  end

  logic ck_rise;
  logic ck_fall;
  logic int_rise;
  logic int_fall;
  logic tx_tick;
  logic rx_tick;
  assign ck_rise  = ck_s2 & ~ck_s3;
  assign ck_fall  = ~ck_s2 & ck_s3;
  assign int_rise = int_tick & ~int_clk_r;
  assign int_fall = int_tick & int_clk_r;

  // R16 R17 R18 per-direction source and edge
  always_comb begin
    if (ssel) begin
      tx_tick = xt ? ck_rise : int_rise;
      rx_tick = xr ? ck_fall : int_fall;
    end else begin
      tx_tick = xt ? ck_rise : int_tick;
      rx_tick = xr ? ck_rise : int_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit path
  logic        tx_busy;
  logic        txd;
  logic        tx_load;
  logic [12:0] frame;
  logic [3:0]  tx_nbits;
  logic [3:0]  pidx;

  // R21 reload when shifter idle
  assign tx_load = ~tx_buffer_empty_r & ~tx_busy;
  assign pidx    = nd + 4'h1;

  // R2 R5 R7 frame bits, LSB first
  always_comb begin
    frame    = 13'h1FFF;
    frame[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i < int'(nd)) begin
        frame[i + 1] = txbuf_r[i];
      end
    end
    if (nine) begin
      frame[9] = ctrl_r[`USF_C_PSELLO - 3];
    end else if (par_on) begin
      frame[pidx] = usf_parity(txbuf_r, n7, psel);
    end
    tx_nbits = nd + {3'h0, par_on} + {3'h0, two_stop_bits} + 4'h2;
  end

  usf_tx u_tx (
    .clk        (SYS_CLK),
    .rst        (RST),
    .load       (tx_load),
    .frame      (frame),
    .nbits      (tx_nbits),
    .short_last (short_last_stop),
    .tick       (tx_tick),
    .os16       (~ssel),
    .busy       (tx_busy),
    .txd        (txd)
  );

  // R11 empty flag; transfer wins over a buffer write in the same cycle
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      tx_buffer_empty_r <= 1'b1;
    end else if (tx_load) begin
      tx_buffer_empty_r <= 1'b1;
    end else if (wr_txb) begin
      tx_buffer_empty_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive path
  logic        rx_line;
  logic [10:0] rx_bits;
  logic        rx_done;
  logic [3:0]  nrx;
  logic [7:0]  rx_data;
  logic        rx_stop;
  logic        ev_fe;
  logic        ev_pe;
  logic        ev_ovr;

  // R6 internal loopback
  assign rx_line = loop ? txd : rx_s2;
  assign nrx     = nd + {3'h0, par_on} + 4'h1;
  assign rx_data = n7 ? {1'b0, rx_bits[6:0]} : rx_bits[7:0];
  assign rx_stop = rx_bits[nd + {3'h0, par_on}];

  usf_rx u_rx (
    .clk  (SYS_CLK),
    .rst  (RST),
    .rxd  (rx_line),
    .tick (rx_tick),
    .os16 (~ssel),
    .nrx  (nrx),
    .bits (rx_bits),
    .done (rx_done)
  );

  // R26 error events
  assign ev_fe  = rx_done & ~rx_stop;
  assign ev_pe  = rx_done & par_on & (rx_bits[nd] != usf_parity(rx_data, n7, psel));
  assign ev_ovr = rx_done & rx_buffer_full_r & ~rd_rxb;

  // R10 holding buffer and full flag, set wins
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      rxbuf_r <= 8'h00;
      rx_ninth_bit_r <= 1'b0;
      rx_buffer_full_r  <= 1'b0;
    end else begin
      if (rx_done) begin
        rxbuf_r <= rx_data;
        rx_ninth_bit_r <= nine & rx_bits[8];
      end
      rx_buffer_full_r <= rx_done | (rx_buffer_full_r & ~rd_rxb);
    end
  end

  // R12 sticky errors; read clears only what the read showed
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ovr_r <= 1'b0;
      fe_r  <= 1'b0;
      pe_r  <= 1'b0;
    end else begin
      ovr_r <= ev_ovr | (ovr_r & ~(rd_stat & PRDATA[`USF_R_OVR]));
      fe_r  <= ev_fe | (fe_r & ~(rd_stat & PRDATA[`USF_R_FE]));
      pe_r  <= ev_pe | (pe_r & ~(rd_stat & PRDATA[`USF_R_PE]));
    end
  end

  // R13 R15 attention and break flags
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      attention_mode_r <= 1'b0;
      brk_r  <= 1'b0;
    end else begin
      if (rx_done && nine && rx_bits[8]) begin
        attention_mode_r <= 1'b0;
      end else if (wr_stat) begin
        attention_mode_r <= PWDATA[`USF_R_ATTENTION_MODE];
      end
      brk_r <= ev_fe | (brk_r & ~rx_s2);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins and requests, all from flops
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      txact_r        <= 1'b0;
      SERIAL_TX_PIN  <= 1'b1;
      SERIAL_TX_OE_N <= 1'b1;
      EXT_CLOCK_OUT  <= 1'b0;
      EXT_CLOCK_OE_N <= 1'b1;
      TX_IRQ         <= 1'b0;
      RX_IRQ         <= 1'b0;
    end else begin
      // R14 active until last stop ends
      txact_r        <= tx_busy | ~tx_buffer_empty_r;
      // R19 pin released when disabled
      SERIAL_TX_PIN  <= txd;
      SERIAL_TX_OE_N <= ~cfg_r[`USF_G_TXEN];
      // Internal sync clock is driven out only when nobody uses the pin as input
      EXT_CLOCK_OUT  <= int_clk_r;
      EXT_CLOCK_OE_N <= ~(ssel & ~xr & ~xt);
      // R23 R24 pending levels
      TX_IRQ         <= tx_buffer_empty_r & cfg_r[`USF_G_ETI];
      RX_IRQ         <= rx_buffer_full_r & cfg_r[`USF_G_ERI];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_setup;
    PSEL && PENABLE && !PREADY;
  endsequence

  a_apb_wait: assert property (s_setup |=> PREADY ##1 !PREADY)
    else $error("apb answer not after one wait");
  a_txbuf_write: assert property (wr_txb |=> !tx_buffer_empty_r ##1 !tx_busy || tx_buffer_empty_r) // R11
    else $error("tx buffer empty flag wrong after write");
  a_rx_buffer_full_read: assert property (rd_rxb && !rx_done |=> !rx_buffer_full_r) // R10
    else $error("rx full not cleared by read");
  a_err_any: assert property (rd && at(PADDR, `USF_IDX_CTRL) |-> // R9
    PRDATA[`USF_C_ERR] == ($past(ovr_r) || $past(fe_r) || $past(pe_r)))
    else $error("error flag read broken");
  a_framing_brk: assert property (ev_fe |=> fe_r && brk_r) // R15
    else $error("framing error not flagged");
  a_overrun: assert property (rx_done && rx_buffer_full_r && !rd_rxb |=> ovr_r && rx_buffer_full_r) // R26
    else $error("overrun not flagged");
  a_nine_nopar: assert property (rx_done && nine |=> $past(pe_r) || !pe_r) // R5
    else $error("parity flagged in nine bit mode");
  a_attention_mode_clear: assert property (rx_done && nine && rx_bits[8] |=> !attention_mode_r) // R13
    else $error("attention not cleared");
  a_loopback: assert property (loop |-> rx_line == txd) // R6
    else $error("loopback path broken");
  a_tx_irq: assert property (tx_buffer_empty_r && cfg_r[`USF_G_ETI] ##1 tx_buffer_empty_r |-> TX_IRQ) // R23
    else $error("tx interrupt missing");
endmodule

// ### inc/usf_params.svh
// Purpose: Register indices, field positions, reset values and timing counts
// Assumes: APB byte address is four times the register index
// Notes:   Header only, no logic
`ifndef USF_PARAMS_SVH
`define USF_PARAMS_SVH
////////////////////////////////////////////////////////////////////////////////
// Register indices (byte address = index * 4)
`define USF_IDX_CTRL    10'h0BA
`define USF_IDX_RXSTAT  10'h0BB
`define USF_IDX_CFG     10'h0BC
`define USF_IDX_TXBUF   10'h0BD
`define USF_IDX_RXBUF   10'h0BE
`define USF_IDX_BAUD    10'h0BF
////////////////////////////////////////////////////////////////////////////////
// serial_ctrl_status fields
`define USF_C_PEN      7
`define USF_C_PSELHI   6
`define USF_C_PSELLO   5
`define USF_C_LENHI    4
`define USF_C_LENLO    3
`define USF_C_ERR      2
`define USF_C_RX_BUFFER_FULL     1
`define USF_C_TX_BUFFER_EMPTY     0
// serial_rx_status fields
`define USF_R_OVR      7
`define USF_R_FE       6
`define USF_R_PE       5
`define USF_R_SPARE    4
`define USF_R_BIT9     3
`define USF_R_ATTENTION_MODE     2
`define USF_R_TXACT    1
`define USF_R_BRK      0
// serial_irq_clock_cfg fields
`define USF_G_TWO_STOP_BITS     7
`define USF_G_SHORT_LAST_STOP    6
`define USF_G_TXEN     5
`define USF_G_SSEL     4
`define USF_G_RX_EXT_CLOCK_SEL    3
`define USF_G_TX_EXT_CLOCK_SEL    2
`define USF_G_ERI      1
`define USF_G_ETI      0
////////////////////////////////////////////////////////////////////////////////
// Reset values
`define USF_CTRL_RST   5'h00
`define USF_CFG_RST    8'h00
`define USF_BAUD_RST   16'h0000
////////////////////////////////////////////////////////////////////////////////
// Timing in oversampling ticks (async bit time is sixteen ticks)
`define USF_OS_BIT     5'h10
`define USF_OS_HALF    5'h08
`define USF_OS_SHORT   5'h0E
`endif

// ### inc/usf_pkg.sv
// Purpose: Shared types and parity helper
// Assumes: Nothing beyond the params header
// Notes:   Parity helper serves both transmit and receive paths
package usf_pkg;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} usf_rx_state_t;

  // Select 00 odd, 01 even, 10 mark, 11 space; seven-bit mode ignores bit 7
  function automatic logic usf_parity(input logic [7:0] d, input logic n7,
                                      input logic [1:0] sel);
    logic p;
    p = ^(n7 ? {1'b0, d[6:0]} : d);
    case (sel)
      2'h0:    usf_parity = ~p;
      2'h1:    usf_parity = p;
      2'h2:    usf_parity = 1'b1;
      default: usf_parity = 1'b0;
    endcase
  endfunction
endpackage

// ### hw/usf_tx.sv
// Purpose: Transmit shifter for a prebuilt frame, LSB first
// Assumes: tick is one cycle; os16 selects sixteen ticks per bit
// Notes:   Line idles high; busy drops at the end of the last stop bit
`timescale 1ns/10ps
`include "usf_params.svh"
module usf_tx import usf_pkg::*; (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        load,
  input  wire logic [12:0] frame,
  input  wire logic [3:0]  nbits,
  input  wire logic        short_last,
  input  wire logic        tick,
  input  wire logic        os16,
  output logic             busy,
  output logic             txd
);
  logic [12:0] sh_r;
  logic [3:0]  left_r;
  logic [4:0]  ph_r;
  logic [4:0]  len;

  // R8 short final stop
  always_comb begin
    len = 5'h01;
    if (os16) begin
      len = (short_last && left_r == 4'h1) ? `USF_OS_SHORT : `USF_OS_BIT;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sh_r   <= 13'h1FFF;
      left_r <= 4'h0;
      ph_r   <= 5'h00;
      busy   <= 1'b0;
    end else if (load) begin
      sh_r   <= frame;
      left_r <= nbits;
      ph_r   <= 5'h00;
      busy   <= 1'b1;
    end else if (busy && tick) begin
      if (ph_r == len - 5'h01) begin
        ph_r   <= 5'h00;
        sh_r   <= {1'b1, sh_r[12:1]};
        left_r <= left_r - 4'h1;
        if (left_r == 4'h1) begin
          busy <= 1'b0;
        end
      end else begin
        ph_r <= ph_r + 5'h01;
      end
    end
  end

  assign txd = sh_r[0];

  a_tx_idle_line: assert property (@(posedge clk) disable iff (rst) // R14
    !busy && !load |=> txd) else $error("tx line not idle high");
endmodule

// ### hw/usf_rx.sv
// Purpose: Receive sampler; start check when os16 is set, then one sample per bit
// Assumes: rxd already synchronised; tick one cycle
// Notes:   Only one stop bit is sampled; bits[] holds data, parity, stop
`timescale 1ns/10ps
`include "usf_params.svh"
module usf_rx import usf_pkg::*; (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       rxd,
  input  wire logic       tick,
  input  wire logic       os16,
  input  wire logic [3:0] nrx,
  output logic [10:0]     bits,
  output logic            done
);
  usf_rx_state_t st_r;
  logic [4:0]    ph_r;
  logic [3:0]    idx_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r  <= RX_IDLE;
      ph_r  <= 5'h00;
      idx_r <= 4'h0;
      bits  <= 11'h000;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (tick) begin
        case (st_r)
          RX_IDLE: begin
            ph_r  <= 5'h00;
            idx_r <= 4'h0;
            if (!rxd) begin
              st_r <= os16 ? RX_START : RX_BITS;
            end
          end
          // R20 half-bit recheck
          RX_START: begin
            if (ph_r == `USF_OS_HALF - 5'h02) begin
              ph_r <= 5'h00;
              st_r <= rxd ? RX_IDLE : RX_BITS;
            end else begin
              ph_r <= ph_r + 5'h01;
            end
          end
          // R25 single stop sampled
          RX_BITS: begin
            if (!os16 || ph_r == `USF_OS_BIT - 5'h01) begin
              ph_r        <= 5'h00;
              bits[idx_r] <= rxd;
              idx_r       <= idx_r + 4'h1;
              if (idx_r == nrx - 4'h1) begin
                done <= 1'b1;
                st_r <= RX_IDLE;
              end
            end else begin
              ph_r <= ph_r + 5'h01;
            end
          end
          default: st_r <= RX_IDLE;
        endcase
      end
    end
  end

  a_rx_false_start: assert property (@(posedge clk) disable iff (rst) // R20
    st_r == RX_START && tick && rxd && ph_r == `USF_OS_HALF - 5'h02 |=> st_r == RX_IDLE)
    else $error("false start not rejected");
endmodule

// ### verification/usf_far_end.sv
// Purpose: Remote serial device on the link pins
// Assumes: Async mode, baud divisor 1, so one bit is 16 SYS_CLK cycles
// Notes:   A released transmit line reads high, as through a pull-up
`timescale 1ns/10ps
module usf_far_end (
  input  wire logic clk,
  input  wire logic tx_pin,
  input  wire logic tx_oe_n,
  output logic      rx_pin
);
  logic        line;
  logic [10:0] got;
  assign line = tx_oe_n ? 1'b1 : tx_pin;
  initial rx_pin = 1'b1;
  ////////////////////////////////////////
  // Data, parity and two stops, each taken once at mid-bit
  always begin
    @(negedge line);
    repeat (8) @(posedge clk);
    for (int i = 0; i < 11; i++) begin
      repeat (16) @(posedge clk);
      got[i] = line;
    end
  end
  ////////////////////////////////////////
  // single stop bit sent; bits[0] is the start bit, LSB first
  task automatic send(input logic [10:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      rx_pin <= bits[i];
      repeat (16) @(posedge clk);
    end
    rx_pin <= 1'b1;
    @(posedge clk);
  endtask
  // Low pulse shorter than half a bit, must not count as a start
  task automatic glitch();
    rx_pin <= 1'b0;
    repeat (4) @(posedge clk);
    rx_pin <= 1'b1;
    @(posedge clk);
  endtask
endmodule

// ### verification/tb.sv
// Purpose: Self-checking bench for the serial transceiver
// Assumes: Baud divisor 1; external clock pin held low
// Notes:   Register reads poll for idle; no fixed latency assumed on APB
`timescale 1ns/10ps
`include "usf_params.svh"
module tb import usf_pkg::*;;
  localparam logic [11:0] A_CTRL = {`USF_IDX_CTRL, 2'b00};
  localparam logic [11:0] A_RXS  = {`USF_IDX_RXSTAT, 2'b00};
  localparam logic [11:0] A_CFG  = {`USF_IDX_CFG, 2'b00};
  localparam logic [11:0] A_TXB  = {`USF_IDX_TXBUF, 2'b00};
  localparam logic [11:0] A_RXB  = {`USF_IDX_RXBUF, 2'b00};
  localparam logic [11:0] A_BAUD = {`USF_IDX_BAUD, 2'b00};
  logic        SYS_CLK = 1'b0;
  logic        RST = 1'b1;
  logic        PSEL = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h00000000;
  logic [31:0] PRDATA;
  logic        PREADY, PSLVERR, SERIAL_TX_PIN, SERIAL_TX_OE_N, TX_IRQ, RX_IRQ;
  logic        EXT_CLOCK_OUT, EXT_CLOCK_OE_N;
  wire logic   SERIAL_RX_PIN;
  logic [7:0]  rdata;
  logic        rerr;
  int          bad_count = 0;
  int          check_count = 0;
  usf_core uut (
    .SYS_CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
    .PSLVERR, .SERIAL_RX_PIN, .SERIAL_TX_PIN, .SERIAL_TX_OE_N, .EXT_CLOCK_IN(1'b0),
    .EXT_CLOCK_OUT, .EXT_CLOCK_OE_N, .TX_IRQ, .RX_IRQ
  );
  usf_far_end far (
    .clk(SYS_CLK), .tx_pin(SERIAL_TX_PIN), .tx_oe_n(SERIAL_TX_OE_N), .rx_pin(SERIAL_RX_PIN)
  );
  always #2.5 SYS_CLK = ~SYS_CLK;
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [10:0] got, input logic [10:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Holds the request until PREADY is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    PSEL    <= 1'b1;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= {24'h000000, d};
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge SYS_CLK);
    end while (PREADY !== 1'b1);
    rdata   = PRDATA[7:0];
    rerr    = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    // Idle edge so the next setup never lands in the same step
    @(posedge SYS_CLK);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string nm);
    apb(1'b0, a, 8'h00);
    chk(nm, {3'h0, rdata}, {3'h0, exp});
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, A_RXS, 8'h00);
      n++;
    end while (rdata[`USF_R_TXACT] !== 1'b0 && n < 100);
    chk("tx active", {10'h000, rdata[`USF_R_TXACT]}, 11'h000);
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    rd(A_CTRL, 8'h01, "ctrl");
    rd(A_RXS, 8'h00, "rx status");
    rd(A_CFG, 8'h00, "cfg");
    rd(12'h000, 8'h00, "unmapped");
    chk("slverr", {10'h000, rerr}, 11'h001);
    chk("ext clock", {9'h000, EXT_CLOCK_OUT, EXT_CLOCK_OE_N}, 11'h001);
  endtask
  // Every parity code, two stops, eight data bits
  task automatic t_tx();
    logic [7:0] d;
    logic       p;
    apb(1'b1, A_BAUD, 8'h01);
    apb(1'b1, A_CFG, 8'hA1);
    for (int s = 0; s < 4; s++) begin
      d = 8'hA5 ^ s[7:0];
      p = (s == 0) ? ~^d : (s == 1) ? ^d : (s == 2);
      apb(1'b1, A_CTRL, {1'b1, s[1:0], 5'h00});
      apb(1'b1, A_TXB, d);
      wait_idle();
      chk("tx frame", far.got, {2'h3, p, d});
    end
    chk("tx irq", {10'h000, TX_IRQ}, 11'h001);
    rd(A_CTRL, 8'hE1, "ctrl");
    apb(1'b1, A_CFG, 8'h00);
    repeat (2) @(posedge SYS_CLK);
    chk("tx oe", {10'h000, SERIAL_TX_OE_N}, 11'h001);
  endtask
  // Low stop bit with the line held low past the frame
  task automatic t_rx();
    apb(1'b1, A_CTRL, 8'h00);
    apb(1'b1, A_CFG, 8'h02);
    far.glitch();
    repeat (180) @(posedge SYS_CLK);
    rd(A_CTRL, 8'h01, "ctrl");
    fork
      far.send(11'h000, 11);
      begin
        repeat (165) @(posedge SYS_CLK);
        chk("rx irq", {10'h000, RX_IRQ}, 11'h001);
        rd(A_CTRL, 8'h07, "ctrl");
        rd(A_RXS, 8'h41, "rx status");
      end
    join
    repeat (4) @(posedge SYS_CLK);
    rd(A_RXS, 8'h00, "rx status");
    rd(A_RXB, 8'h00, "rx buffer");
    rd(A_CTRL, 8'h01, "ctrl");
    // Line still low after the stop sample reads as a new start
    repeat (130) @(posedge SYS_CLK);
    rd(A_CTRL, 8'h03, "ctrl");
    apb(1'b0, A_RXB, 8'h00);
    // Seven data bits carrying a wrong odd parity bit
    apb(1'b1, A_CTRL, 8'h88);
    far.send({1'b1, 1'b0, 7'h55, 1'b0}, 10);
    rd(A_RXS, 8'h20, "rx status");
    rd(A_RXB, 8'h55, "rx buffer");
  endtask
  // Nine bits with parity enable ignored; second frame overruns
  task automatic t_nine();
    apb(1'b1, A_CTRL, 8'h90);
    apb(1'b1, A_RXS, 8'h04);
    far.send({1'b1, 1'b0, 8'h5A, 1'b0}, 11);
    far.send({1'b1, 1'b1, 8'hC3, 1'b0}, 11);
    repeat (4) @(posedge SYS_CLK);
    rd(A_RXS, 8'h88, "rx status");
    rd(A_RXB, 8'hC3, "rx buffer");
    apb(1'b1, A_CTRL, 8'h38);
    apb(1'b1, A_TXB, 8'h96);
    wait_idle();
    repeat (4) @(posedge SYS_CLK);
    rd(A_RXS, 8'h08, "rx status");
    rd(A_RXB, 8'h96, "rx buffer");
  endtask
  ////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge SYS_CLK);
    RST <= 1'b0;
    @(posedge SYS_CLK);
    t_reset();
    t_tx();
    t_rx();
    t_nine();
    stop_test();
  end
  // Whole run needs about 2200 cycles
  initial begin
    repeat (20000) @(posedge SYS_CLK);
    bad_count++;
    stop_test();
  end
endmodule
